// >>> dv/config_pin_function_mux_tb.sv
// Self-checking bench for the configurable pin function mux.
// Assumes the pad model above and a free-running 48 MHz reference.

`timescale 1ns/1ps
`default_nettype none

module config_pin_function_mux_tb;
	import cpfm_pkg::*;
	logic clk_sys = 1'b0, resetn = 1'b0, refClk48 = 1'b0;
	logic nvCfgValid = 1'b0, nvCfgSuspPull = 1'b0;
	logic [FN_W-1:0] nvCfgFunc = FN_TRISTATE;
	logic usbConfigured = 1'b0, usbSuspend = 1'b0, chargerDetect = 1'b0;
	logic bbWrStrobe_n = 1'b1, bbRdStrobe_n = 1'b1, txEmpty = 1'b0;
	logic rxFull = 1'b0, sofPulse = 1'b0, gpioOutVal = 1'b0;
	logic gpioOutEn = 1'b0, sdaPullLow = 1'b0, extEn = 1'b0, extVal = 1'b0;
	logic sclDrv = 1'b1, chkReq = 1'b0, chkDly = 1'b0;
	logic cfgPinIn, sdaIn, sclIn, cfgPinOut, cfgPinOe_n, cfgPinPullUp;
	logic cfgPinPullDown, busPowerPresent, keepAwake, gpioInVal, sdaOut;
	logic sdaOe_n, sdaInVal, sclInVal, nvLoadReq, cfgLoaded;
	logic [19:0] expQ[$];
	int n_mismatch = 0, n_checks = 0;
	int seed = 32'h6A0C48C5;
	logic [4:0] codes [15] = '{FN_TRISTATE, FN_DRIVE_HIGH, FN_DRIVE_LOW,
		FN_POWER_EN, FN_SLEEP, FN_GPIO, FN_CHARGER, FN_CHARGER_N,
		FN_WR_STROBE, FN_RD_STROBE, FN_TX_EMPTY, FN_RX_FULL,
		FN_BUS_SENSE, FN_KEEP_AWAKE, 5'h1F};

	// ------------------------------------------------------------
	// Clocks and instances
	// ------------------------------------------------------------
	initial begin
		forever #4 clk_sys = ~clk_sys;
	end
	// Reference is unrelated in phase to the system clock
	initial begin
		#3.1;
		forever #10.417 refClk48 = ~refClk48;
	end

	cpfm_pin_mux cpfm_pin_mux_inst (.clk_sys(clk_sys), .resetn(resetn),
		.refClk48(refClk48), .nvCfgValid(nvCfgValid), .nvCfgFunc(nvCfgFunc),
		.nvCfgSuspPull(nvCfgSuspPull), .usbConfigured(usbConfigured),
		.usbSuspend(usbSuspend), .chargerDetect(chargerDetect),
		.bbWrStrobe_n(bbWrStrobe_n), .bbRdStrobe_n(bbRdStrobe_n),
		.txEmpty(txEmpty), .rxFull(rxFull), .sofPulse(sofPulse),
		.gpioOutVal(gpioOutVal), .gpioOutEn(gpioOutEn),
		.sdaPullLow(sdaPullLow), .cfgPinIn(cfgPinIn), .sdaIn(sdaIn),
		.sclIn(sclIn), .cfgPinOut(cfgPinOut), .cfgPinOe_n(cfgPinOe_n),
		.cfgPinPullUp(cfgPinPullUp), .cfgPinPullDown(cfgPinPullDown),
		.busPowerPresent(busPowerPresent), .keepAwake(keepAwake),
		.gpioInVal(gpioInVal), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
		.sdaInVal(sdaInVal), .sclInVal(sclInVal), .nvLoadReq(nvLoadReq),
		.cfgLoaded(cfgLoaded));

	cpfm_pad_model cpfm_pad_model_inst (.clk_sys(clk_sys),
		.cfgPinOut(cfgPinOut), .cfgPinOe_n(cfgPinOe_n),
		.cfgPinPullUp(cfgPinPullUp), .cfgPinPullDown(cfgPinPullDown),
		.extEn(extEn), .extVal(extVal), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
		.sclDrv(sclDrv), .cfgPinIn(cfgPinIn), .sdaIn(sdaIn), .sclIn(sclIn));

	// ------------------------------------------------------------
	// Compare tasks, verdict and result monitor
	// ------------------------------------------------------------
	task automatic results();
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : results

	task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chkVal

	task automatic chkWord(input logic [9:0] got, input logic [19:0] e);
		chkVal({22'h0, got & e[19:10]}, {22'h0, e[9:0] & e[19:10]});
	endtask : chkWord

	// A note is due one edge after the driver set its inputs
	always @(posedge clk_sys) chkDly <= chkReq;
	always @(negedge clk_sys) begin
		if (chkDly && expQ.size() > 0) begin
			chkWord({cfgPinOe_n, cfgPinOe_n ? 1'b0 : cfgPinOut, cfgPinPullUp,
				cfgPinPullDown, busPowerPresent, keepAwake, gpioInVal,
				sdaOe_n, sdaOut, sclInVal}, expQ.pop_front());
		end
	end

	// ------------------------------------------------------------
	// Stimulus
	// ------------------------------------------------------------
	// Pin bits of the expected word: {oe_n, out, pull-up, pull-down}
	function automatic logic [3:0] pinExp(input logic [4:0] f,
		input logic [7:0] v, input logic ge, gv, sp);
		logic oe;
		logic o;
		logic pd;
		oe = 1'b0;
		o = 1'b0;
		case (f)
			FN_DRIVE_HIGH: o = 1'b1;
			FN_DRIVE_LOW:  o = 1'b0;
			FN_POWER_EN:   o = ~(v[0] & ~v[1]);
			FN_SLEEP:      o = ~v[1];
			FN_GPIO: begin
				oe = ~ge;
				o = gv & ge;
			end
			FN_CHARGER:    o = v[2];
			FN_CHARGER_N:  oe = ~v[2];
			FN_WR_STROBE:  o = v[3];
			FN_RD_STROBE:  o = v[4];
			FN_TX_EMPTY:   o = ~v[5];
			FN_RX_FULL:    o = ~v[6];
			default:       oe = 1'b1;
		endcase
		pd = oe & sp & v[1];
		return {oe, o, oe & ~pd, pd};
	endfunction : pinExp

	task automatic doCfg(input logic [4:0] f, input logic sp);
		int n;
		@(posedge clk_sys);
		resetn <= 1'b0;
		repeat (12) @(posedge clk_sys);
		chkVal({cfgPinOe_n, cfgPinPullUp, cfgPinPullDown, sdaOe_n, nvLoadReq,
			cfgLoaded}, 6'h34);
		resetn <= 1'b1;
		for (n = 0; n < 20 && nvLoadReq !== 1'b1; n++) @(negedge clk_sys);
		if (nvLoadReq !== 1'b1) begin
			n_mismatch++;
			results();
		end
		chkVal(cfgPinOe_n, 1'b1);
		@(posedge clk_sys);
		nvCfgValid <= 1'b1;
		nvCfgFunc <= f;
		nvCfgSuspPull <= sp;
		for (n = 0; n < 20 && cfgLoaded !== 1'b1; n++) @(negedge clk_sys);
		if (cfgLoaded !== 1'b1) begin
			n_mismatch++;
			results();
		end
		@(posedge clk_sys);
		nvCfgValid <= 1'b0;
	endtask : doCfg

	// Random levels each cycle; pad-side levels held in blocks of eight
	task automatic runMix(input logic [4:0] f, input logic sp);
		logic [31:0] r;
		logic [9:0] e;
		logic [9:0] m;
		logic ge, gv, ev, sc, padE;
		for (int s = 0; s < 64; s++) begin
			@(posedge clk_sys);
			r = $random(seed);
			if (s % 8 == 0) begin
				{ge, gv, ev, sc} = r[12:9];
			end
			{chargerDetect, usbSuspend, usbConfigured} <= r[2:0];
			{rxFull, txEmpty, bbRdStrobe_n, bbWrStrobe_n} <= r[6:3];
			sdaPullLow <= r[7];
			{gpioOutEn, gpioOutVal, extVal, sclDrv} <= {ge, gv, ev, sc};
			extEn <= (f == FN_GPIO || f == FN_BUS_SENSE || f == FN_KEEP_AWAKE);
			padE = (f == FN_GPIO && ge) ? gv : ev;
			e = {pinExp(f, {1'b0, r[6:0]}, ge, gv, sp),
				(f == FN_BUS_SENSE) & padE, (f == FN_KEEP_AWAKE) & ~padE,
				padE, ~r[7], 1'b0, sc};
			m = (s % 8 == 7) ? {6'h3F, extEn, 3'h7} : 10'h3C6;
			expQ.push_back({m, e});
			chkReq <= 1'b1;
		end
		@(posedge clk_sys);
		chkReq <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask : runMix

	// Counts rising edges, or toggles, of the pin over a window
	task automatic countPin(input int cyc, input bit tog, output int cnt);
		logic prev;
		cnt = 0;
		@(negedge clk_sys);
		prev = cfgPinOut;
		repeat (cyc) begin
			@(negedge clk_sys);
			if (cfgPinOut !== prev && (tog || cfgPinOut === 1'b1)) cnt++;
			prev = cfgPinOut;
		end
	endtask : countPin

	task automatic clkTest(input logic [4:0] f, input int mhz);
		int c;
		doCfg(f, 1'b0);
		usbSuspend <= 1'b0;
		countPin(1000, 0, c);
		chkVal(c >= mhz * 8 - 2 && c <= mhz * 8 + 2, 1'b1);
		chkVal(cfgPinOe_n, 1'b0);
		@(posedge clk_sys);
		usbSuspend <= 1'b1;
		repeat (4) @(posedge clk_sys);
		countPin(200, 1, c);
		chkVal({c[30:0], cfgPinOut}, 32'h0);
		@(posedge clk_sys);
		usbSuspend <= 1'b0;
		countPin(500, 0, c);
		chkVal(c >= mhz * 4 - 2 && c <= mhz * 4 + 2, 1'b1);
	endtask : clkTest

	initial begin
		int c, nSof;
		logic sp;
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 15; i++) begin
				sp = p[0];
				doCfg(codes[i], sp);
				runMix(codes[i], sp);
			end
		end
		clkTest(FN_CLK_FAST, FAST_MHZ);
		clkTest(FN_CLK_MID, MID_MHZ);
		clkTest(FN_CLK_SLOW, SLOW_MHZ);
		// Timestamp: spaced start-of-frame pulses, one toggle each
		doCfg(FN_TIMESTAMP, 1'b0);
		nSof = 0;
		fork
			countPin(230, 1, c);
			begin
				for (int s = 0; s < 200; s++) begin
					@(posedge clk_sys);
					sp = ~sofPulse & $random(seed);
					sofPulse <= sp;
					nSof += sp;
				end
				// A pulse left high would toggle on every cycle
				@(posedge clk_sys);
				sofPulse <= 1'b0;
			end
		join
		chkVal(c, nSof);
		// A second configuration offer is ignored until the next reset
		doCfg(FN_DRIVE_HIGH, 1'b0);
		@(posedge clk_sys);
		nvCfgValid <= 1'b1;
		nvCfgFunc <= FN_DRIVE_LOW;
		repeat (4) @(posedge clk_sys);
		nvCfgValid <= 1'b0;
		chkVal({cfgPinOe_n, cfgPinOut}, 2'h1);
		// Data line pulled low reads back low, released reads high
		sdaPullLow <= 1'b1;
		repeat (6) @(posedge clk_sys);
		chkVal({sdaOe_n, sdaInVal}, 2'h0);
		sdaPullLow <= 1'b0;
		repeat (6) @(posedge clk_sys);
		chkVal({sdaOe_n, sdaInVal}, 2'h3);
		results();
	end
endmodule : config_pin_function_mux_tb

`default_nettype wire

// >>> dv/cpfm_pad_model.sv
// Far-side model of the configurable pin and the I2C pads.
// Assumes the design's pad controls are registered on clk_sys and that
// the bench chooses when the outside party drives the pin.

`timescale 1ns/1ps
`default_nettype none

module cpfm_pad_model (
	input  wire logic clk_sys,
	input  wire logic cfgPinOut,
	input  wire logic cfgPinOe_n,
	input  wire logic cfgPinPullUp,
	input  wire logic cfgPinPullDown,
	input  wire logic extEn,
	input  wire logic extVal,
	input  wire logic sdaOut,
	input  wire logic sdaOe_n,
	input  wire logic sclDrv,
	output logic      cfgPinIn,
	output logic      sdaIn,
	output logic      sclIn
);
	// ------------------------------------------------------------
	// Pin level
	// ------------------------------------------------------------
	logic lastLvl_r = 1'b0;
	logic pinLvl;

	// Undriven and unpulled pin floats: show the inverse of the last level
	// so that a stale value never passes for a real one
	assign pinLvl = !cfgPinOe_n ? cfgPinOut :
		extEn ? extVal :
		cfgPinPullDown ? 1'b0 : cfgPinPullUp ? 1'b1 : ~lastLvl_r;
	always @(posedge clk_sys) begin
		lastLvl_r <= pinLvl;
	end
	assign cfgPinIn = pinLvl;

	// Data line has a bus pull-up; clock is the master's alone
	assign sdaIn = !sdaOe_n ? sdaOut : 1'b1;
	assign sclIn = sclDrv;
endmodule : cpfm_pad_model

`default_nettype wire

// >>> rtl/cpfm_clk_div.sv
// Divider for the pin clock outputs.
// Assumes refEdge is a one-cycle pulse per rising edge of the 48 MHz
// reference, already brought into the system clock domain.

`timescale 1ns/1ps
`default_nettype none

module cpfm_clk_div
	import cpfm_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rstSync_n,
	input  wire logic refEdge,
	input  wire logic run,
	output logic      clkFast,
	output logic      clkMid,
	output logic      clkSlow
);

	logic [DIV_W-1:0] divCnt_r;
	logic [DIV_W-1:0] divCnt_nxt;

	// ------------------------------------------------------------
	// Synchronous binary count of reference edges
	// ------------------------------------------------------------
	// Cleared while stopped so every clock restarts low and in phase
	assign divCnt_nxt = !run ? '0 :
		(refEdge ? divCnt_r + DIV_W'(1) : divCnt_r);

	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			divCnt_r <= '0;
		end else begin
			divCnt_r <= divCnt_nxt;
		end
	end

	// Each bit halves the rate of the one below it
	assign clkFast = divCnt_r[FAST_BIT];
	assign clkMid  = divCnt_r[MID_BIT];
	assign clkSlow = divCnt_r[SLOW_BIT];

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_div_stop_clear: assert property (
		@(posedge clk_sys) disable iff (!rstSync_n)
		!run |=> divCnt_r == '0)
		else $error("divider not cleared while stopped");

endmodule : cpfm_clk_div

`default_nettype wire

// >>> rtl/cpfm_pin_mux.sv
// Function mux and pad control for the configurable control pin,
// plus the pad side of the I2C data and clock lines.
// Assumes USB state, strobes and buffer flags come from logic on
// clk_sys; pad inputs and the 48 MHz reference are asynchronous.
//
// Contract
// - pin carries one stored function only
// - tri-state option never drives the pin
// - power enable low configured, high suspended
// - pull up, or pull low in suspend
// - sleep indicator low during whole suspend
// - clock options give 24, 12, 6 MHz
// - clock outputs stop during suspend
// - charger detect drives high when attached
// - inverted charger detect is open drain
// - bit-bang write or read strobe out
// - active-low flag when transmit buffer empty
// - active-low flag when receive buffer full
// - bus power sense pin is input
// - timestamp toggles on each start-of-frame
// - keep-awake low input blocks suspend
// - general purpose bit-bang port bit
// - I2C data open drain, never high
// - I2C clock input only, no stretching
// - clocks derived from 48 MHz reference

`timescale 1ns/1ps
`default_nettype none

module cpfm_pin_mux
	import cpfm_pkg::*;
(
	input  wire logic          clk_sys,
	input  wire logic          resetn,
	input  wire logic          refClk48,
	input  wire logic          nvCfgValid,
	input  wire logic [FN_W-1:0] nvCfgFunc,
	input  wire logic          nvCfgSuspPull,
	input  wire logic          usbConfigured,
	input  wire logic          usbSuspend,
	input  wire logic          chargerDetect,
	input  wire logic          bbWrStrobe_n,
	input  wire logic          bbRdStrobe_n,
	input  wire logic          txEmpty,
	input  wire logic          rxFull,
	input  wire logic          sofPulse,
	input  wire logic          gpioOutVal,
	input  wire logic          gpioOutEn,
	input  wire logic          sdaPullLow,
	input  wire logic          cfgPinIn,
	input  wire logic          sdaIn,
	input  wire logic          sclIn,
	output logic               cfgPinOut,
	output logic               cfgPinOe_n,
	output logic               cfgPinPullUp,
	output logic               cfgPinPullDown,
	output logic               busPowerPresent,
	output logic               keepAwake,
	output logic               gpioInVal,
	output logic               sdaOut,
	output logic               sdaOe_n,
	output logic               sdaInVal,
	output logic               sclInVal,
	output logic               nvLoadReq,
	output logic               cfgLoaded
);

	logic          rstMeta_r;
	logic          rstSync_r;
	logic          rstSync_n;
	logic [3:0]    padMeta_r;
	logic [3:0]    padSync_r;
	logic          refPrev_r;
	cpfm_state_t   state_r;
	cpfm_state_t   state_nxt;
	logic [FN_W-1:0] func_r;
	logic          suspPull_r;
	logic          stamp_r;
	logic          running;
	logic          pinSync;
	logic          refSync;
	logic          refEdge;
	logic          clkFast;
	logic          clkMid;
	logic          clkSlow;

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	// Assertion is immediate; release waits two edges
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rstMeta_r <= 1'b0;
			rstSync_r <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstSync_r <= rstMeta_r;
		end
	end

	assign rstSync_n = rstSync_r;

	// ------------------------------------------------------------
	// Pad input synchronisers
	// ------------------------------------------------------------
	// Bits: 3 reference clock, 2 I2C clock, 1 I2C data, 0 pin
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			padMeta_r <= 4'h6; // I2C lines idle high: no false edge
			padSync_r <= 4'h6;
			refPrev_r <= 1'b0;
		end else begin
			padMeta_r <= {refClk48, sclIn, sdaIn, cfgPinIn};
			padSync_r <= padMeta_r;
			refPrev_r <= padSync_r[3];
		end
	end

	assign pinSync = padSync_r[0];
	assign refSync = padSync_r[3];
	// Edge detect reads the second stage and its delayed copy
	assign refEdge = refSync & ~refPrev_r;

	// ------------------------------------------------------------
	// Configuration load
	// ------------------------------------------------------------
	// Pin stays released until the stored function arrives
	assign running   = state_r == CPFM_RUN;
	assign state_nxt = (state_r == CPFM_LOAD && nvCfgValid)
		? CPFM_RUN : state_r;

	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			state_r    <= CPFM_LOAD;
			func_r     <= FN_RESET;
			suspPull_r <= SUSP_PULL_RST;
		end else begin
			state_r <= state_nxt;
			if (state_r == CPFM_LOAD && nvCfgValid) begin
				func_r     <= nvCfgFunc;
				suspPull_r <= nvCfgSuspPull;
			end
		end
	end

	// ------------------------------------------------------------
	// Clock outputs and frame toggle
	// ------------------------------------------------------------
	// Suspend stops the divider; no clock escapes while asleep
	cpfm_clk_div u_clk_div (
		.clk_sys   (clk_sys),
		.rstSync_n (rstSync_n),
		.refEdge   (refEdge),
		.run       (!usbSuspend),
		.clkFast   (clkFast),
		.clkMid    (clkMid),
		.clkSlow   (clkSlow)
	);

	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			stamp_r <= 1'b0;
		end else if (sofPulse) begin
			stamp_r <= ~stamp_r;
		end
	end

	// ------------------------------------------------------------
	// Function decode
	// ------------------------------------------------------------
	logic isTri;
	logic isHigh;
	logic isLow;
	logic isPwr;
	logic isSleep;
	logic isFast;
	logic isMid;
	logic isSlow;
	logic isGpio;
	logic isChg;
	logic isChgN;
	logic isWr;
	logic isRd;
	logic isTx;
	logic isRx;
	logic isSense;
	logic isStamp;
	logic isKeep;
	logic pwrLevel;

	assign isTri   = func_r == FN_TRISTATE;
	assign isHigh  = func_r == FN_DRIVE_HIGH;
	assign isLow   = func_r == FN_DRIVE_LOW;
	assign isPwr   = func_r == FN_POWER_EN;
	assign isSleep = func_r == FN_SLEEP;
	assign isFast  = func_r == FN_CLK_FAST;
	assign isMid   = func_r == FN_CLK_MID;
	assign isSlow  = func_r == FN_CLK_SLOW;
	assign isGpio  = func_r == FN_GPIO;
	assign isChg   = func_r == FN_CHARGER;
	assign isChgN  = func_r == FN_CHARGER_N;
	assign isWr    = func_r == FN_WR_STROBE;
	assign isRd    = func_r == FN_RD_STROBE;
	assign isTx    = func_r == FN_TX_EMPTY;
	assign isRx    = func_r == FN_RX_FULL;
	assign isSense = func_r == FN_BUS_SENSE;
	assign isStamp = func_r == FN_TIMESTAMP;
	assign isKeep  = func_r == FN_KEEP_AWAKE;

	// High until configured, low while awake, high again in suspend
	assign pwrLevel = ~(usbConfigured & ~usbSuspend);

	// ------------------------------------------------------------
	// Pad drive selection
	// ------------------------------------------------------------
	logic fnVal;
	logic fnDrive;
	logic pinOut_nxt;
	logic pinDrive_nxt;
	logic pullDown_nxt;
	logic pullUp_nxt;

	// Level the selected function puts on the pin
	assign fnVal =
		isHigh  ? 1'b1 :
		isLow   ? 1'b0 :
		isPwr   ? pwrLevel :
		isSleep ? ~usbSuspend :
		isFast  ? clkFast :
		isMid   ? clkMid :
		isSlow  ? clkSlow :
		isGpio  ? gpioOutVal :
		isChg   ? chargerDetect :
		isWr    ? bbWrStrobe_n :
		isRd    ? bbRdStrobe_n :
		isTx    ? ~txEmpty :
		isRx    ? ~rxFull :
		isStamp ? stamp_r : 1'b0;

	// Whether the pad driver is on; unknown codes leave it off
	assign fnDrive =
		isTri | isSense | isKeep ? 1'b0 :
		isChgN ? chargerDetect :
		isGpio ? gpioOutEn :
		(isHigh | isLow | isPwr | isSleep | isFast | isMid |
		 isSlow | isChg | isWr | isRd | isTx | isRx | isStamp);

	assign pinDrive_nxt = running & fnDrive;
	assign pinOut_nxt   = running & fnVal;
	// Pulls only matter while the pad is not driven
	assign pullDown_nxt = ~pinDrive_nxt & suspPull_r & usbSuspend;
	assign pullUp_nxt   = ~pinDrive_nxt & ~pullDown_nxt;

	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			cfgPinOut      <= 1'b0;
			cfgPinOe_n     <= 1'b1;
			cfgPinPullUp   <= 1'b1;
			cfgPinPullDown <= 1'b0;
		end else begin
			cfgPinOut      <= pinOut_nxt;
			cfgPinOe_n     <= ~pinDrive_nxt;
			cfgPinPullUp   <= pullUp_nxt;
			cfgPinPullDown <= pullDown_nxt;
		end
	end

	// ------------------------------------------------------------
	// Pin as input, and the I2C pads
	// ------------------------------------------------------------
	// Data pad output is tied low; only its enable ever moves
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			busPowerPresent <= 1'b0;
			keepAwake       <= 1'b0;
			gpioInVal       <= 1'b0;
			sdaOut          <= 1'b0;
			sdaOe_n         <= 1'b1;
			sdaInVal        <= 1'b1;
			sclInVal        <= 1'b1;
			nvLoadReq       <= 1'b0;
			cfgLoaded       <= 1'b0;
		end else begin
			busPowerPresent <= running & isSense & pinSync;
			keepAwake       <= running & isKeep & ~pinSync;
			gpioInVal       <= pinSync;
			sdaOut          <= 1'b0;
			sdaOe_n         <= ~sdaPullLow;
			sdaInVal        <= padSync_r[1];
			sclInVal        <= padSync_r[2];
			nvLoadReq       <= state_nxt == CPFM_LOAD;
			cfgLoaded       <= state_nxt == CPFM_RUN;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstSync_n);

	chk_load_pin_released: assert property (
		!running |=> cfgPinOe_n)
		else $error("pin driven before configuration load");

	chk_tristate_never_driven: assert property (
		running && isTri |=> cfgPinOe_n)
		else $error("tri-state option drove the pin");

	chk_drive_low_const: assert property (
		running && isLow |=> !cfgPinOe_n && !cfgPinOut)
		else $error("constant low option not driven low");

	chk_power_en_level: assert property (
		running && isPwr && usbSuspend |=> !cfgPinOe_n && cfgPinOut)
		else $error("power enable not high in suspend");

	chk_power_en_awake: assert property (
		running && isPwr && usbConfigured && !usbSuspend
		|=> !cfgPinOut)
		else $error("power enable not low when configured");

	chk_pull_down_suspend: assert property (
		running && isTri && suspPull_r && usbSuspend
		|=> cfgPinPullDown && !cfgPinPullUp)
		else $error("suspend pull-down not applied");

	chk_sleep_level: assert property (
		running && isSleep |=> cfgPinOut == !$past(usbSuspend))
		else $error("sleep indicator wrong level");

	chk_clock_stopped: assert property (
		(running && isFast && usbSuspend) [*3] |=> !cfgPinOut)
		else $error("clock output running in suspend");

	chk_charger_open_drain: assert property (
		running && isChgN
		|=> !cfgPinOut && cfgPinOe_n == !$past(chargerDetect))
		else $error("inverted charger pin not open drain");

	chk_tx_empty_flag: assert property (
		running && isTx |=> cfgPinOut == !$past(txEmpty))
		else $error("transmit empty flag wrong level");

	chk_stamp_toggle: assert property (
		running && isStamp && sofPulse
		|=> ##1 cfgPinOut != $past(cfgPinOut))
		else $error("timestamp did not toggle on frame");

	chk_keep_awake_in: assert property (
		running && isKeep && !pinSync |=> keepAwake && cfgPinOe_n)
		else $error("keep-awake input not honoured");

	chk_sda_open_drain: assert property (
		!sdaOe_n |-> !sdaOut)
		else $error("data line driven high");

	cov_config_load: cover property (
		!running ##1 running);

	cov_clock_suspend: cover property (
		running && isMid && !usbSuspend ##1 usbSuspend [*4]
		##[1:300] !usbSuspend);

	cov_stamp_frames: cover property (
		running && isStamp && sofPulse ##[1:20] sofPulse);

	cov_charger_seen: cover property (
		running && isChgN && chargerDetect ##1 !chargerDetect);

endmodule : cpfm_pin_mux

`default_nettype wire

// >>> rtl/cpfm_pkg.sv
// Shared constants for the configurable control pin function mux.
// Assumes the stored configuration delivers one function code and one
// suspend pull option as a single load, on the system clock.

package cpfm_pkg;

	// ------------------------------------------------------------
	// Pin function codes held in nonvolatile configuration
	// ------------------------------------------------------------
	localparam int          FN_W           = 5;
	localparam logic [4:0]  FN_TRISTATE    = 5'h00;
	localparam logic [4:0]  FN_DRIVE_HIGH  = 5'h01;
	localparam logic [4:0]  FN_DRIVE_LOW   = 5'h02;
	localparam logic [4:0]  FN_POWER_EN    = 5'h03;
	localparam logic [4:0]  FN_SLEEP       = 5'h04;
	localparam logic [4:0]  FN_CLK_FAST    = 5'h05;
	localparam logic [4:0]  FN_CLK_MID     = 5'h06;
	localparam logic [4:0]  FN_CLK_SLOW    = 5'h07;
	localparam logic [4:0]  FN_GPIO        = 5'h08;
	localparam logic [4:0]  FN_CHARGER     = 5'h09;
	localparam logic [4:0]  FN_CHARGER_N   = 5'h0A;
	localparam logic [4:0]  FN_WR_STROBE   = 5'h0B;
	localparam logic [4:0]  FN_RD_STROBE   = 5'h0C;
	localparam logic [4:0]  FN_TX_EMPTY    = 5'h0D;
	localparam logic [4:0]  FN_RX_FULL     = 5'h0E;
	localparam logic [4:0]  FN_BUS_SENSE   = 5'h0F;
	localparam logic [4:0]  FN_TIMESTAMP   = 5'h10;
	localparam logic [4:0]  FN_KEEP_AWAKE  = 5'h11;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [4:0]  FN_RESET       = 5'h00;
	localparam logic        SUSP_PULL_RST  = 1'b0;

	// ------------------------------------------------------------
	// Clock tree figures, in MHz
	// ------------------------------------------------------------
	localparam int          OSC_MHZ        = 12;
	localparam int          REF_MHZ        = 48;
	localparam int          FAST_MHZ       = 24;
	localparam int          MID_MHZ        = 12;
	localparam int          SLOW_MHZ       = 6;
	localparam int          SYS_MHZ        = 125;
	// Counter bit that toggles at each output rate
	localparam int          FAST_BIT       = $clog2(REF_MHZ / FAST_MHZ) - 1;
	localparam int          MID_BIT        = $clog2(REF_MHZ / MID_MHZ) - 1;
	localparam int          SLOW_BIT       = $clog2(REF_MHZ / SLOW_MHZ) - 1;
	localparam int          DIV_W          = SLOW_BIT + 1;

	// ------------------------------------------------------------
	// Control states
	// ------------------------------------------------------------
	typedef enum logic [0:0] {
		CPFM_LOAD,
		CPFM_RUN
	} cpfm_state_t;

endpackage : cpfm_pkg
